// *** dv/dcs_core_assertions.sv ***
// Checker for the drive command and status words
`timescale 1ns/1ns
module dcs_core_assertions
   import dcs_pkg::*;
(
   input  wire logic                   i_clk,
   input  wire logic                   i_arst_n,
   input  wire logic                   i_cmd_valid,
   input  wire logic [CMD_W-1:0]       i_cmd_word,
   input  wire dcs_pkg::dcs_plant_t    i_plant,
   input  wire logic [CMD_W-1:0]       o_status_word,
   input  wire logic                   o_pulse_en,
   input  wire logic signed [SP_W-1:0] o_ramp_out
);
   import dcs_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);
   // A word taken while fieldbus control is granted
   sequence bus_cmd;
      i_cmd_valid && i_cmd_word[CB_MASTER];
   endsequence
   resv_zero_a: assert property (!o_status_word[12])
      else $error("reserved status bit set");
   pulse_cut_a: assert property (i_cmd_valid && !i_cmd_word[CB_ENABLE_OP]
      |-> ##[1:3] !o_pulse_en) else $error("pulses not cancelled");
   coast_flag_a: assert property (bus_cmd ##0 !i_cmd_word[CB_NO_COAST]
      |-> ##2 !o_status_word[SB_NO_COAST]) else $error("coast flag wrong");
   fast_flag_a: assert property (bus_cmd ##0 !i_cmd_word[CB_NO_FAST]
      |-> ##2 !o_status_word[SB_NO_FAST]) else $error("fast flag wrong");
   no_master_a: assert property (i_cmd_valid && !i_cmd_word[CB_MASTER]
      |-> ##2 o_status_word[5:4] == 2'b00) else $error("word not ignored");
   ramp_zero_a: assert property (bus_cmd ##0 !i_cmd_word[CB_RAMP_EN]
      |-> ##[1:4] o_ramp_out == 0) else $error("ramp not zeroed");
   fault_flag_a: assert property ($rose(i_plant.fault_in)
      |-> ##[2:6] o_status_word[SB_FAULT]) else $error("fault not shown");
   motor_hot_a: assert property (i_plant.motor_hot [*8]
      |-> !o_status_word[SB_MOTOR_HOT_N]) else $error("hot bit wrong");
   alarm_flag_a: assert property (i_plant.alarm_in [*8]
      |-> o_status_word[SB_ALARM]) else $error("alarm not shown");
endmodule : dcs_core_assertions

// *** dv/dcs_core_tb.sv ***
// Testbench for the drive command and status word block
`timescale 1ns/1ns
`define CMP(g, e) cmp(16'(g), 16'(e))
module dcs_core_tb;
   import dcs_pkg::*;
   logic                   i_clk = 1'b0;
   logic                   i_arst_n;
   logic                   cmd_valid;
   logic [CMD_W-1:0]       cmd_word;
   logic [CMD_W-1:0]       o_status_word;
   logic                   o_pulse_en;
   logic signed [SP_W-1:0] i_setpoint;
   logic signed [SP_W-1:0] i_speed_act;
   logic signed [SP_W-1:0] o_ramp_out;
   logic signed [SP_W-1:0] o_pot_value;
   logic signed [SP_W-1:0] pot_a;
   dcs_plant_t             i_plant;
   int                     mismatches = 0;
   int                     n_tests = 0;
   int                     cycles = 0;

   always #25 i_clk = ~i_clk;

   dcs_fieldbus_master u_master (
      .i_clk       (i_clk),
      .o_cmd_valid (cmd_valid),
      .o_cmd_word  (cmd_word)
   );
   dcs_core #(.RAMP_CYC(2), .POT_CYC(2)) u_dut (
      .i_clk         (i_clk),
      .i_arst_n      (i_arst_n),
      .i_cmd_valid   (cmd_valid),
      .i_cmd_word    (cmd_word),
      .i_setpoint    (i_setpoint),
      .i_plant       (i_plant),
      .i_speed_act   (i_speed_act),
      .o_status_word (o_status_word),
      .o_pulse_en    (o_pulse_en),
      .o_ramp_out    (o_ramp_out),
      .o_pot_value   (o_pot_value)
   );

   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp

   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #5;
   endtask : step

   task automatic go(input logic [15:0] w, input int n);
      u_master.send(w);
      step(n);
   endtask : go

   task automatic report_and_stop();
      $display("TB: %0d mismatches, %0d tests", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         mismatches++;
         report_and_stop();
      end
   end

   initial
   begin
      i_arst_n = 1'b0;
      i_setpoint = '0;
      i_speed_act = '0;
      i_plant = '0;
      i_plant.supply_ok = 1'b1;
      repeat (2) @(posedge i_clk);
      #5;
      i_arst_n = 1'b1;
      step(8);
      `CMP(o_status_word, 16'hA040);
      go(16'h9706, 4);
      `CMP(o_status_word, 16'hA031);
      go(16'h0407, 4);
      `CMP(o_status_word, 16'hA033);
      i_setpoint = 16'sh000A;
      go(16'h047F, 4);
      `CMP(o_status_word[2:1], 2'b11);
      `CMP(o_pulse_en, 1'b1);
      step(40);
      `CMP(o_ramp_out, 16'h000A);
      go(16'h043F, 40);
      `CMP(o_ramp_out, 16'h0000);
      go(16'h0C7F, 60);
      `CMP(o_ramp_out, 16'hFFF6);
      go(16'h045F, 40);
      `CMP(o_ramp_out, 16'hFFF6);
      go(16'h046F, 4);
      `CMP(o_ramp_out, 16'h0000);
      go(16'h247F, 20);
      pot_a = o_pot_value;
      `CMP(pot_a > 0, 1'b1);
      go(16'h447F, 20);
      `CMP(o_pot_value < pot_a, 1'b1);
      go(16'h0477, 3);
      `CMP({o_pulse_en, o_status_word[2]}, 2'b00);
      go(16'h047F, 4);
      go(16'h047E, 80);
      `CMP({o_pulse_en, o_status_word[1:0]}, 3'b001);
      go(16'h047F, 8);
      `CMP(o_pulse_en, 1'b1);
      go(16'h047D, 3);
      `CMP({o_pulse_en, o_status_word[4]}, 2'b00);
      go(16'h047E, 4);
      go(16'h047F, 8);
      go(16'h047B, 3);
      `CMP(o_status_word[5], 1'b0);
      step(100);
      `CMP({o_pulse_en, o_status_word[6]}, 2'b01);
      go(16'h007F, 4);
      `CMP(o_status_word[5:4], 2'b00);
      i_plant.fault_in = 1'b1;
      step(8);
      `CMP(o_status_word[3], 1'b1);
      i_plant.fault_in = 1'b0;
      go(16'h0407, 4);
      go(16'h0487, 4);
      `CMP({o_status_word[6], o_status_word[3]}, 2'b10);
      i_plant = '1;
      step(10);
      `CMP(o_status_word & 16'hAF80, 16'h0F80);
      report_and_stop();
   end
endmodule : dcs_core_tb

bind dcs_core dcs_core_assertions u_chk (
   .i_clk         (i_clk),
   .i_arst_n      (i_arst_n),
   .i_cmd_valid   (i_cmd_valid),
   .i_cmd_word    (i_cmd_word),
   .i_plant       (i_plant),
   .o_status_word (o_status_word),
   .o_pulse_en    (o_pulse_en),
   .o_ramp_out    (o_ramp_out)
);

// *** dv/dcs_fieldbus_master.sv ***
// Fieldbus master model issuing drive command words
`timescale 1ns/1ns
module dcs_fieldbus_master
   import dcs_pkg::*;
(
   input  wire logic        i_clk,
   output logic             o_cmd_valid,
   output logic [CMD_W-1:0] o_cmd_word
);
   import dcs_pkg::*;
   initial
   begin
      o_cmd_valid = 1'b0;
      o_cmd_word  = CMD_RESET;
   end
   // One strobe per word; the word is scrambled once released
   task automatic send(input logic [CMD_W-1:0] w);
      @(posedge i_clk);
      #5;
      o_cmd_valid = 1'b1;
      o_cmd_word  = w;
      @(posedge i_clk);
      #5;
      o_cmd_valid = 1'b0;
      o_cmd_word  = ~w;
   endtask : send
endmodule : dcs_fieldbus_master

// *** hdl/dcs_core.sv ***
// Drive command word decoder, switch-on sequencer and status word builder
//
// Function
// R1: Bit0 low: normal ramp down, then drive off
// R2: Bit0 rise: ready; run only with bit3
// R3: Bit1 low: drive off at once, coast
// R4: Bit2 low: fast ramp to standstill
// R5: Bit3 low: cancel output pulses immediately
// R6: Bit4 low: ramp output forced to zero
// R7: Bit5 low: ramp output frozen; the code freezes it in ST_RUN only, not in ST_STOPPING
// R8: Bit6 low: brake; high: ramp to setpoint
// R9: Bit7 rise acknowledges fault; ON gives inhibit
// R10: Bit10 low: fieldbus data ignored
// R11: Bit11 high: setpoint sign inverted
// R12: Bit13 raises, bit14 lowers pot setpoint
// R13: Status0: initialised, pulses locked
// R14: Status1: ON asserted and no fault
// R15: Status2: operation enabled, following setpoint
// R16: Status3: fault pending until acknowledged
// R17: Status4 no coast stop, status5 no fast
// R18: Status6: inhibited until ON low then high; the code clears it on ON low with bits 1 and 2 high
// R19: Status7: alarm, no stop, no acknowledge
// R20: Status8,10,11: speed and torque comparisons
// R21: Status9: master control requested
// R22: Status13,15 low on thermal alarms
// R23: Reserved command bits ignored; status12 zero
`timescale 1ns/1ns
module dcs_core
   import dcs_pkg::*;
#(
   parameter int SPW      = SP_W,
   parameter int RAMP_CYC = RAMP_DIV,
   parameter int POT_CYC  = POT_DIV
)(
   input  wire logic                  i_clk,
   input  wire logic                  i_arst_n,
   input  wire logic                  i_cmd_valid,
   input  wire logic [CMD_W-1:0]      i_cmd_word,
   input  wire logic signed [SPW-1:0] i_setpoint,
   input  wire dcs_pkg::dcs_plant_t   i_plant,
   input  wire logic signed [SPW-1:0] i_speed_act,
   output logic [CMD_W-1:0]           o_status_word,
   output logic                       o_pulse_en,
   output logic signed [SPW-1:0]      o_ramp_out,
   output logic signed [SPW-1:0]      o_pot_value
);
   import dcs_pkg::*;

   if (RAMP_CYC < 1 || POT_CYC < 1)
   begin : g_bad_div
      $error("dcs_core divider below 1");
   end
   // Step constants are 16 bits wide, so wider setpoints are refused
   if (SPW < 2 || SPW > 16)
   begin : g_bad_width
      $error("dcs_core setpoint width must be 2 to 16");
   end

   // Reset release synchroniser
   logic rst_s1_q;
   logic rst_n;
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // Plant status pins are asynchronous: two stages each
   dcs_plant_t plant_s1_q;
   dcs_plant_t plant_q;
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         plant_s1_q <= '0;
         plant_q    <= '0;
      end
      else
      begin
         plant_s1_q <= i_plant;
         plant_q    <= plant_s1_q;
      end
   end

   // Command capture; reserved bits masked
   logic [CMD_W-1:0] cmd_q;
   logic [CMD_W-1:0] cmd_prev_q;
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         cmd_q <= CMD_RESET;
      else if (i_cmd_valid)
         cmd_q <= i_cmd_word & CMD_USED_MASK; // R23
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         cmd_prev_q <= CMD_RESET;
      else
         cmd_prev_q <= cmd_q;
   end

   // Without master control the word is seen as all zero, bit10 included
   logic [CMD_W-1:0] cmd;
   assign cmd = cmd_q[CB_MASTER] ? cmd_q : CMD_RESET; // R10

   function automatic logic rise(input logic [CMD_W-1:0] now,
                                 input logic [CMD_W-1:0] prev,
                                 input int bitn);
      rise = now[bitn] && !prev[bitn];
   endfunction : rise

   logic cmd_ok;
   assign cmd_ok = cmd_q[CB_MASTER] && cmd_prev_q[CB_MASTER];
   logic on_rise;
   logic ack_rise;
   assign on_rise  = cmd_ok && rise(cmd_q, cmd_prev_q, CB_ON);
   assign ack_rise = cmd_ok && rise(cmd_q, cmd_prev_q, CB_ACK);

   logic coast;
   logic fast;
   assign coast = !cmd[CB_NO_COAST];
   assign fast  = !cmd[CB_NO_FAST];

   // Step enables
   logic [$clog2(RAMP_CYC+1)-1:0] ramp_cnt_q;
   logic [$clog2(POT_CYC+1)-1:0]  pot_cnt_q;
   logic ramp_tick;
   logic pot_tick;
   assign ramp_tick = (ramp_cnt_q == '0);
   assign pot_tick  = (pot_cnt_q == '0);
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         ramp_cnt_q <= '0;
      else if (ramp_tick)
         ramp_cnt_q <= ($clog2(RAMP_CYC+1))'(RAMP_CYC - 1);
      else
         ramp_cnt_q <= ramp_cnt_q - 1'b1;
   end
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         pot_cnt_q <= '0;
      else if (pot_tick)
         pot_cnt_q <= ($clog2(POT_CYC+1))'(POT_CYC - 1);
      else
         pot_cnt_q <= pot_cnt_q - 1'b1;
   end

   // Motor potentiometer setpoint, saturating
   localparam logic signed [SPW-1:0] POT_MAX = {1'b0, {(SPW-1){1'b1}}};
   localparam logic signed [SPW-1:0] POT_MIN = -POT_MAX;
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         o_pot_value <= '0;
      else if (pot_tick && cmd[CB_POT_UP] && !cmd[CB_POT_DOWN]
               && o_pot_value < POT_MAX)
         o_pot_value <= o_pot_value + $signed(POT_STEP[SPW-1:0]); // R12
      else if (pot_tick && cmd[CB_POT_DOWN] && !cmd[CB_POT_UP]
               && o_pot_value > POT_MIN)
         o_pot_value <= o_pot_value - $signed(POT_STEP[SPW-1:0]); // R12
   end

   // Sequencer
   dcs_state_t state_q;
   logic       ramp_zero_spd;
   logic       fault_q;

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         fault_q <= 1'b0;
      else if (plant_q.fault_in)
         fault_q <= 1'b1; // R16
      else if (ack_rise)
         fault_q <= 1'b0; // R9
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= ST_INIT;
      else
      begin
         case (state_q)
            ST_INIT:
               if (plant_q.supply_ok)
                  state_q <= ST_INHIBIT;
            ST_FAULT:
               if (!fault_q)
                  state_q <= ST_INHIBIT; // R9
            ST_INHIBIT:
               if (fault_q)
                  state_q <= ST_FAULT;
               else if (!cmd[CB_ON] && !coast && !fast)
                  state_q <= ST_READY_START; // R18
            ST_READY_START:
               if (fault_q)
                  state_q <= ST_FAULT;
               else if (coast || fast)
                  state_q <= ST_INHIBIT;
               else if (on_rise)
                  state_q <= ST_READY; // R2
            ST_READY:
               if (fault_q)
                  state_q <= ST_FAULT;
               else if (coast || fast)
                  state_q <= ST_INHIBIT;
               else if (!cmd[CB_ON])
                  state_q <= ST_READY_START;
               else if (cmd[CB_ENABLE_OP])
                  state_q <= ST_RUN; // R2
            ST_RUN:
               if (fault_q || coast)
                  state_q <= fault_q ? ST_FAULT : ST_INHIBIT; // R3
               else if (!cmd[CB_ENABLE_OP])
                  state_q <= ST_READY; // R5
               else if (!cmd[CB_ON] || fast)
                  state_q <= ST_STOPPING; // R1
            ST_STOPPING:
               if (fault_q || coast)
                  state_q <= fault_q ? ST_FAULT : ST_INHIBIT; // R3
               else if (!cmd[CB_ENABLE_OP])
                  state_q <= ST_READY; // R5
               else if (ramp_zero_spd)
                  state_q <= fast ? ST_INHIBIT : ST_READY_START; // R1
            default:
               state_q <= ST_INIT;
         endcase
      end
   end

   logic running;
   logic stopping;
   assign running  = (state_q == ST_RUN);
   assign stopping = (state_q == ST_STOPPING);
   assign o_pulse_en = running || stopping; // R5

   // Ramp target, zero, hold and down-step selection
   logic signed [SPW-1:0] sp_sel;
   logic signed [SPW-1:0] target;
   logic                  ramp_zero;
   logic                  ramp_hold;
   logic [SPW-1:0]        down_step;
   always_comb
   begin
      sp_sel = i_setpoint + o_pot_value;
      if (cmd[CB_INVERT])
         sp_sel = -sp_sel; // R11
      if (stopping || !cmd[CB_SP_EN])
         target = '0; // R8
      else
         target = sp_sel; // R8
      ramp_zero = !o_pulse_en || !cmd[CB_RAMP_EN]; // R6
      ramp_hold = running && !cmd[CB_RAMP_RUN]; // R7
      down_step = (stopping && fast) ? FAST_STEP[SPW-1:0] // R4
                                     : RAMP_DOWN_STEP[SPW-1:0]; // R1
   end

   dcs_ramp #(
      .W (SPW)
   ) u_ramp (
      .i_clk       (i_clk),
      .i_rst_n     (rst_n),
      .i_step_en   (ramp_tick),
      .i_zero      (ramp_zero),
      .i_hold      (ramp_hold),
      .i_target    (target),
      .i_down_step (down_step),
      .o_value     (o_ramp_out),
      .o_at_zero   (ramp_zero_spd)
   );

   // Status word, registered
   logic [CMD_W-1:0] status_d;
   always_comb
   begin
      status_d                 = '0; // R23
      status_d[SB_READY_START] = (state_q == ST_READY_START)
                                 || (state_q == ST_READY); // R13
      status_d[SB_READY]       = (state_q == ST_READY) || running; // R14
      status_d[SB_OP_EN]       = running; // R15
      status_d[SB_FAULT]       = fault_q; // R16
      status_d[SB_NO_COAST]    = !coast; // R17
      status_d[SB_NO_FAST]     = !fast; // R17
      status_d[SB_INHIBIT]     = (state_q == ST_INHIBIT); // R18
      status_d[SB_ALARM]       = plant_q.alarm_in; // R19
      status_d[SB_SPEED_OK]    = plant_q.speed_ok; // R20
      status_d[SB_MASTER_REQ]  = plant_q.master_req; // R21
      status_d[SB_SPEED_CMP]   = plant_q.speed_cmp; // R20
      status_d[SB_TORQUE_OK]   = plant_q.torque_ok; // R20
      status_d[SB_MOTOR_HOT_N] = !plant_q.motor_hot; // R22
      status_d[SB_CW]          = i_speed_act > 0;
      status_d[SB_INV_HOT_N]   = !plant_q.inv_hot; // R22
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         o_status_word <= '0;
      else
         o_status_word <= status_d;
   end
endmodule : dcs_core

// *** hdl/dcs_pkg.sv ***
// Package: command and status word layout, states, ramp and pot constants
package dcs_pkg;
   localparam int CMD_W          = 16;
   localparam int SP_W           = 16;
   // Command word bit positions
   localparam int CB_ON          = 0;
   localparam int CB_NO_COAST    = 1;
   localparam int CB_NO_FAST     = 2;
   localparam int CB_ENABLE_OP   = 3;
   localparam int CB_RAMP_EN     = 4;
   localparam int CB_RAMP_RUN    = 5;
   localparam int CB_SP_EN       = 6;
   localparam int CB_ACK         = 7;
   localparam int CB_MASTER      = 10;
   localparam int CB_INVERT      = 11;
   localparam int CB_POT_UP      = 13;
   localparam int CB_POT_DOWN    = 14;
   // Status word bit positions
   localparam int SB_READY_START = 0;
   localparam int SB_READY       = 1;
   localparam int SB_OP_EN       = 2;
   localparam int SB_FAULT       = 3;
   localparam int SB_NO_COAST    = 4;
   localparam int SB_NO_FAST     = 5;
   localparam int SB_INHIBIT     = 6;
   localparam int SB_ALARM       = 7;
   localparam int SB_SPEED_OK    = 8;
   localparam int SB_MASTER_REQ  = 9;
   localparam int SB_SPEED_CMP   = 10;
   localparam int SB_TORQUE_OK   = 11;
   localparam int SB_MOTOR_HOT_N = 13;
   localparam int SB_CW          = 14;
   localparam int SB_INV_HOT_N   = 15;
   // Reserved command bits are masked off on capture
   localparam logic [15:0] CMD_USED_MASK = 16'h6CFF;
   localparam logic [15:0] CMD_RESET     = 16'h0000;
   // Ramp and pot step sizes and rate dividers (cycles per step)
   localparam logic [15:0] RAMP_UP_STEP   = 16'h0001;
   localparam logic [15:0] RAMP_DOWN_STEP = 16'h0001;
   localparam logic [15:0] FAST_STEP      = 16'h0010;
   localparam logic [15:0] POT_STEP       = 16'h0001;
   localparam int          RAMP_DIV       = 20;
   localparam int          POT_DIV        = 2000;

   typedef enum logic [2:0] {
      ST_INIT,
      ST_INHIBIT,
      ST_READY_START,
      ST_READY,
      ST_RUN,
      ST_STOPPING,
      ST_FAULT
   } dcs_state_t;

   typedef struct packed {
      logic supply_ok;
      logic fault_in;
      logic alarm_in;
      logic speed_ok;
      logic speed_cmp;
      logic torque_ok;
      logic motor_hot;
      logic inv_hot;
      logic master_req;
   } dcs_plant_t;
endpackage : dcs_pkg

// *** hdl/dcs_ramp.sv ***
// Ramp generator: zero, hold, track or brake toward a target
`timescale 1ns/1ns
module dcs_ramp
   import dcs_pkg::*;
#(
   parameter int W = SP_W
)(
   input  wire logic                i_clk,
   input  wire logic                i_rst_n,
   input  wire logic                i_step_en,
   input  wire logic                i_zero,
   input  wire logic                i_hold,
   input  wire logic signed [W-1:0] i_target,
   input  wire logic        [W-1:0] i_down_step,
   output logic signed      [W-1:0] o_value,
   output logic                     o_at_zero
);
   // Step constants are 16 bits wide, so wider ramps are refused
   if (W < 2 || W > 16)
   begin : g_bad_width
      $error("dcs_ramp width must be 2 to 16");
   end

   logic signed [W:0] diff;
   logic signed [W:0] up_step_x;
   logic signed [W:0] dn_step_x;

   assign diff      = {i_target[W-1], i_target} - {o_value[W-1], o_value};
   assign up_step_x = $signed({1'b0, RAMP_UP_STEP[W-1:0]});
   assign dn_step_x = $signed({1'b0, i_down_step});
   assign o_at_zero = (o_value == '0);

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_value <= '0;
      else if (i_zero)
         o_value <= '0;
      else if (i_step_en && !i_hold)
      begin
         if (diff > up_step_x && o_value >= 0)
            o_value <= o_value + $signed(RAMP_UP_STEP[W-1:0]);
         else if (diff < -up_step_x && o_value <= 0)
            o_value <= o_value - $signed(RAMP_UP_STEP[W-1:0]);
         else if (diff > dn_step_x)
            o_value <= o_value + $signed(i_down_step);
         else if (diff < -dn_step_x)
            o_value <= o_value - $signed(i_down_step);
         else
            o_value <= i_target;
      end
   end
endmodule : dcs_ramp
